/* rtl/sqs_pkg.sv */
/*
  shared constants and types for the adc strobe sequencer.
  assumes a single 200 MHz system clock; all times are counted in its cycles.
*/
package sqs_pkg;

  // number of strobed monitor channels, one strobe line each
  localparam int NCH = 8;
  // system clock rate in MHz
  localparam int CLK_MHZ = 200;

  // strobe timing figures in ns
  localparam int T_LOW_NS = 5000;        // least low time after a fall
  localparam int T_CUR_HIGH_NS = 5000;   // least high time, current channel
  localparam int T_TEMP_HIGH_NS = 10000; // least high time, temperature channel
  localparam int T_SETTLE_NS = 5000;     // temperature settling before sampling

  // least times round up to whole cycles
  localparam logic [11:0] LOW_CYC = 12'((T_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] CUR_HIGH_CYC = 12'((T_CUR_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] TEMP_HIGH_CYC = 12'((T_TEMP_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [11:0] SETTLE_CYC = 12'((T_SETTLE_NS * CLK_MHZ + 999) / 1000);
  // saturation value of the per-channel age counters
  localparam logic [11:0] AGE_MAX = 12'hfff;

  // cycles between conversion done and the return to idle that raises entry_ready again
  localparam logic [11:0] TURN_CYC = 12'h00a;
  // converter clock period is DIV_FACTOR * (1 + divider setting) cycles
  localparam logic [9:0] DIV_FACTOR = 10'h004;
  // acquisition lasts ACQ_BASE + stc converter clocks
  localparam logic [8:0] ACQ_BASE = 9'h002;

  // one entry of the sample sequence
  typedef struct packed {
    logic [2:0] chan;   // channel number
    logic strobed;      // channel needs a strobe
    logic temp;         // temperature channel (else current)
    logic [7:0] stc;    // sample time control factor
  } sqs_entry_t;

  // sequencer states
  typedef enum logic [2:0] {
    SQS_IDLE = 3'h0,
    SQS_SWITCH = 3'h1,
    SQS_SETTLE = 3'h2,
    SQS_ACQ = 3'h3,
    SQS_CONV = 3'h4,
    SQS_TURN = 3'h5
  } sqs_state_t;

endpackage : sqs_pkg

/* rtl/sqs_clk_div.sv */
/*
  converter clock divider: one-cycle enable every 4*(1+setting) system clocks.
  assumes the divider setting is held steady by its source, same clock domain.
*/
`timescale 1ns/100ps
module sqs_clk_div (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] div_set,
  output logic tick
);

  // free-running phase counter
  logic [9:0] phase;
  // last phase value of one converter period
  logic [9:0] last;

  assign last = 10'(DIV_FACTOR_MUL(div_set) - 10'h001);

  function automatic logic [9:0] DIV_FACTOR_MUL(input logic [7:0] s);
    DIV_FACTOR_MUL = 10'(sqs_pkg::DIV_FACTOR * ({2'h0, s} + 10'h001));
  endfunction : DIV_FACTOR_MUL

  // phase counter and registered tick
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= 10'h000;
      tick <= 1'b0;
    end else if (phase >= last) begin
      // wrap; a lowered setting also wraps at once
      phase <= 10'h000;
      tick <= 1'b1;
    end else begin
      phase <= 10'(phase + 10'h001);
      tick <= 1'b0;
    end
  end

  // tick spacing at the smallest setting
  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (rst)
    tick && div_set == 8'h00 && $stable(div_set) |=> !tick [*3] ##1 tick)
    else $error("converter clock enable spacing wrong");

endmodule : sqs_clk_div

/* rtl/sqs_seq.sv */
/*
  adc strobe sequencer: takes sequence entries, drives per-channel strobes,
  inserts temperature settling, runs acquisition and conversion phases.
  assumes the converter reports adc_done on this clock and entries come from
  same-domain logic with a valid/ready handshake.
*/
`timescale 1ns/100ps
module sqs_seq (
  input wire logic clk,
  input wire logic rst,
  input wire sqs_pkg::sqs_entry_t entry,
  input wire logic entry_valid,
  output logic entry_ready,
  input wire logic [7:0] div_set,
  input wire logic adc_done,
  output logic [sqs_pkg::NCH-1:0] strobe,
  output logic adc_sample,
  output logic adc_conv_start,
  output logic adc_clk_en
);

  // current state
  sqs_pkg::sqs_state_t st;
  // entry being processed
  sqs_pkg::sqs_entry_t cur;
  // shared phase timer for settling and turnaround
  logic [11:0] tmr;
  // converter clocks seen in acquisition
  logic [8:0] acq_cnt;
  // raised strobe belongs to a temperature channel
  logic hold_temp;
  // cycles since each strobe last changed, saturating
  logic [11:0] age [sqs_pkg::NCH];
  // per-channel low time met
  logic [sqs_pkg::NCH-1:0] low_ok;
  // per-channel high time met
  logic [sqs_pkg::NCH-1:0] high_ok;
  // strobe of the current entry is already up
  logic keep;
  // some raised strobe may drop now
  logic drop_ok;

  // converter clock enable, registered inside the divider
  sqs_clk_div u_div (
    .clk(clk),
    .rst(rst),
    .div_set(div_set),
    .tick(adc_clk_en)
  );

  // per-channel age counters and pulse-width checks
  genvar g;
  generate
    for (g = 0; g < sqs_pkg::NCH; g++) begin : g_chan
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          // start saturated so the first raise is not delayed
          age[g] <= sqs_pkg::AGE_MAX;
        end else if (strobe[g] != $past(strobe[g])) begin
          age[g] <= 12'h001;
        end else if (age[g] != sqs_pkg::AGE_MAX) begin
          age[g] <= 12'(age[g] + 12'h001);
        end
      end
      assign low_ok[g] = !strobe[g] && age[g] >= sqs_pkg::LOW_CYC;
      // high time check by channel type
      assign high_ok[g] = strobe[g] &&
        age[g] >= (hold_temp ? sqs_pkg::TEMP_HIGH_CYC : sqs_pkg::CUR_HIGH_CYC);

      AST_LOW_MIN: assert property (@(posedge clk) disable iff (rst)
        $rose(strobe[g]) |-> $past(age[g]) >= sqs_pkg::LOW_CYC)
        else $error("strobe raised before low time");
      AST_CUR_HIGH: assert property (@(posedge clk) disable iff (rst)
        $fell(strobe[g]) |-> $past(age[g]) >= sqs_pkg::CUR_HIGH_CYC)
        else $error("strobe dropped before current high time");
      AST_TEMP_HIGH: assert property (@(posedge clk) disable iff (rst)
        $fell(strobe[g]) && $past(hold_temp) |-> $past(age[g]) >= sqs_pkg::TEMP_HIGH_CYC)
        else $error("temperature strobe dropped before high time");
    end
  endgenerate

  assign keep = cur.strobed && strobe[cur.chan];
  assign drop_ok = |high_ok;

  // sequencing state machine, strobes and converter controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= sqs_pkg::SQS_IDLE;
      cur <= '0;
      entry_ready <= 1'b0;
      strobe <= '0;
      hold_temp <= 1'b0;
      tmr <= 12'h000;
      acq_cnt <= 9'h000;
      adc_sample <= 1'b0;
      adc_conv_start <= 1'b0;
    end else begin
      unique case (st)
        sqs_pkg::SQS_IDLE: begin
          // strobe of the last channel stays up until a switch
          if (entry_ready && entry_valid) begin
            cur <= entry;
            entry_ready <= 1'b0;
            st <= sqs_pkg::SQS_SWITCH;
          end else begin
            entry_ready <= 1'b1;
          end
        end
        sqs_pkg::SQS_SWITCH: begin
          if (|strobe && !keep) begin
            // only once high time is met
            if (drop_ok) begin
              strobe <= '0;
            end
          end else if (cur.strobed && !keep) begin
            if (low_ok[cur.chan]) begin
              strobe[cur.chan] <= 1'b1;
              hold_temp <= cur.temp;
            end
          end else if (cur.strobed && cur.temp) begin
            tmr <= 12'h000;
            st <= sqs_pkg::SQS_SETTLE;
          end else begin
            acq_cnt <= 9'h000;
            adc_sample <= 1'b1;
            st <= sqs_pkg::SQS_ACQ;
          end
        end
        sqs_pkg::SQS_SETTLE: begin
          if (tmr == 12'(sqs_pkg::SETTLE_CYC - 12'h001)) begin
            acq_cnt <= 9'h000;
            adc_sample <= 1'b1;
            st <= sqs_pkg::SQS_ACQ;
          end else begin
            tmr <= 12'(tmr + 12'h001);
          end
        end
        sqs_pkg::SQS_ACQ: begin
          if (acq_cnt == 9'(sqs_pkg::ACQ_BASE + {1'b0, cur.stc})) begin
            // strobe is up here for strobed channels
            adc_sample <= 1'b0;
            adc_conv_start <= 1'b1;
            st <= sqs_pkg::SQS_CONV;
          end else if (adc_clk_en) begin
            acq_cnt <= 9'(acq_cnt + 9'h001);
          end
        end
        sqs_pkg::SQS_CONV: begin
          // start is a one-cycle pulse; wait for the converter
          adc_conv_start <= 1'b0;
          if (adc_done && !adc_conv_start) begin
            tmr <= 12'h000;
            st <= sqs_pkg::SQS_TURN;
          end
        end
        sqs_pkg::SQS_TURN: begin
          if (tmr == 12'(sqs_pkg::TURN_CYC - 12'h001)) begin
            st <= sqs_pkg::SQS_IDLE;
          end else begin
            tmr <= 12'(tmr + 12'h001);
          end
        end
        default: begin
          // illegal code, recover to idle
          st <= sqs_pkg::SQS_IDLE;
        end
      endcase
    end
  end

  // checks of sequencing relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_CONV_STROBED: assert property (
    adc_conv_start && cur.strobed |-> strobe[cur.chan])
    else $error("conversion started without strobe");
  AST_SETTLE_LEN: assert property (
    st == sqs_pkg::SQS_ACQ && $past(st) == sqs_pkg::SQS_SETTLE |->
    $past(tmr) == 12'(sqs_pkg::SETTLE_CYC - 12'h001) && strobe[cur.chan])
    else $error("settling interval wrong");
  AST_ACQ_LEN: assert property (
    $rose(adc_conv_start) |-> $past(acq_cnt) == 9'(sqs_pkg::ACQ_BASE + {1'b0, cur.stc}))
    else $error("acquisition length wrong");
  AST_CONV_AFTER_ACQ: assert property (
    $rose(adc_conv_start) |-> $fell(adc_sample) && $past(st) == sqs_pkg::SQS_ACQ)
    else $error("conversion before sampling ended");
  AST_ONE_STROBE: assert property (
    $onehot0(strobe))
    else $error("more than one strobe up");
  AST_HOLD_STROBE: assert property (
    cur.strobed && st inside {sqs_pkg::SQS_ACQ, sqs_pkg::SQS_CONV} |-> strobe[cur.chan])
    else $error("strobe dropped while processing");
  AST_TURN_LEN: assert property (
    st == sqs_pkg::SQS_IDLE && $past(st) == sqs_pkg::SQS_TURN |->
    $past(tmr) == 12'(sqs_pkg::TURN_CYC - 12'h001))
    else $error("turnaround length wrong");

  COV_TEMP_RUN: cover property ($rose(adc_conv_start) && cur.temp && cur.strobed);
  COV_CUR_RUN: cover property ($rose(adc_conv_start) && !cur.temp && cur.strobed);
  COV_SWITCH_DROP: cover property ($fell(|strobe));
  COV_PLAIN_RUN: cover property ($rose(adc_conv_start) && !cur.strobed);

endmodule : sqs_seq

/* testbench/sqs_adc_model.sv */
/*
  converter model: answers each start pulse with a one-cycle adc_done
  after conv_cyc clocks.
  assumes conv_cyc is held steady by the bench while a conversion runs.
*/
`timescale 1ns/100ps
module sqs_adc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic adc_conv_start,
  input wire logic [11:0] conv_cyc,
  output logic adc_done
);
  logic [11:0] left; // cycles still to run, zero when idle

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left <= 12'h000;
      adc_done <= 1'b0;
    end else begin
      // done pulses for one cycle only, at the end of the count
      adc_done <= (left == 12'h001);
      if (adc_conv_start) begin
        left <= conv_cyc;
      end else if (left != 12'h000) begin
        left <= left - 12'h001;
      end
    end
  end
endmodule : sqs_adc_model

/* testbench/testbench.sv */
/*
  bench for the strobe sequencer: scenarios feed sequence entries, a
  monitor times every strobe edge.
  assumes sqs_adc_model answers the start pulses; inputs move at negedge.
*/
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sqs_pkg::sqs_entry_t entry = '0;
  logic entry_valid = 1'b0;
  logic [7:0] div_set = 8'h00;
  logic [11:0] conv_cyc = 12'h028; // prompt converter at first
  logic entry_ready, adc_done, adc_sample, adc_conv_start, adc_clk_en;
  logic [sqs_pkg::NCH-1:0] strobe, prev_strobe, kind; // kind high: temperature
  logic cur_temp = 1'b0; // flavour of the entry last offered
  int err_total = 0;
  int n_checks = 0;
  int hi [sqs_pkg::NCH];
  int lo [sqs_pkg::NCH];

  sqs_seq u_dut (.clk(clk), .rst(rst), .entry(entry), .entry_valid(entry_valid),
    .entry_ready(entry_ready), .div_set(div_set), .adc_done(adc_done), .strobe(strobe),
    .adc_sample(adc_sample), .adc_conv_start(adc_conv_start), .adc_clk_en(adc_clk_en));
  sqs_adc_model u_adc (.clk(clk), .rst(rst), .adc_conv_start(adc_conv_start),
    .conv_cyc(conv_cyc), .adc_done(adc_done));

  // 200 MHz system clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // strobe timing monitor; low counts start saturated like the design's
  always @(negedge clk) begin
    for (int i = 0; i < sqs_pkg::NCH; i++) begin
      if (rst) begin
        hi[i] = 0;
        lo[i] = 100000;
      end else if (strobe[i] && !prev_strobe[i]) begin
        check(32'(lo[i] >= sqs_pkg::LOW_CYC), 32'h1);
        hi[i] = 1;
        kind[i] = cur_temp;
      end else if (!strobe[i] && prev_strobe[i]) begin
        check(32'(hi[i] >= (kind[i] ? sqs_pkg::TEMP_HIGH_CYC : sqs_pkg::CUR_HIGH_CYC)),
          32'h1);
        lo[i] = 1;
      end else if (strobe[i]) begin
        hi[i]++;
      end else if (lo[i] < 100000) begin
        lo[i]++;
      end
    end
    if (!rst) check(32'($onehot0(strobe)), 32'h1);
    prev_strobe = strobe;
  end

  // selects the output that a wait watches
  function automatic logic pick(input int sel);
    case (sel)
      0: return entry_ready;
      1: return adc_sample;
      2: return adc_done;
      3: return adc_clk_en;
      default: return strobe[entry.chan];
    endcase
  endfunction : pick

  // counts falling edges until the output shows want; a hang ends the run
  task automatic wait_cnt(input int sel, input logic want, output int n);
    n = 0;
    while (pick(sel) !== want) begin
      @(negedge clk);
      n++;
      if (n > 6000) begin
        err_total++;
        conclude();
      end
    end
  endtask : wait_cnt

  // offers one entry and holds it until the sequencer takes it
  task automatic send(input logic [2:0] ch, input logic sb, input logic tp,
    input logic [7:0] st);
    int n;
    entry = '{chan: ch, strobed: sb, temp: tp, stc: st};
    entry_valid = 1'b1;
    cur_temp = tp;
    wait_cnt(0, 1'b1, n);
    @(negedge clk);
    entry_valid = 1'b0;
  endtask : send

  // one whole sample, phases judged as they pass
  task automatic run_one(input logic [2:0] ch, input logic sb, input logic tp,
    input logic [7:0] st);
    int n;
    int a;
    int p;
    p = 4 * (1 + div_set);
    send(ch, sb, tp, st);
    wait_cnt(4, sb, n);
    wait_cnt(1, 1'b1, n);
    check(32'(tp ? (n >= 998 && n <= 1003) : (!sb || n < 8)), 32'h1);
    wait_cnt(1, 1'b0, a);
    check(32'(adc_conv_start), 32'h1);
    check(32'(strobe[ch]), 32'(sb));
    check(32'(a >= (1 + st) * p && a <= (2 + st) * p + 2), 32'h1);
    wait_cnt(2, 1'b1, n);
    wait_cnt(0, 1'b1, n);
    check(32'(n >= sqs_pkg::TURN_CYC && n <= 13), 32'h1);
  endtask : run_one

  task automatic t_temp();
    run_one(3'h1, 1'b1, 1'b1, 8'h00);
    run_one(3'h1, 1'b1, 1'b1, 8'h00);
    $display("temperature test done");
  endtask : t_temp

  task automatic t_switch();
    // channel one comes back only after channel two
    run_one(3'h2, 1'b1, 1'b0, 8'h03);
    run_one(3'h1, 1'b1, 1'b1, 8'h02);
    run_one(3'h5, 1'b0, 1'b0, 8'h01);
    check(32'(strobe), 32'h0);
    $display("switch test done");
  endtask : t_switch

  task automatic t_div();
    int n;
    for (int d = 0; d < 3; d++) begin
      div_set = 8'((1 << d) - 1);
      wait_cnt(3, 1'b1, n);
      @(negedge clk);
      wait_cnt(3, 1'b1, n);
      @(negedge clk);
      wait_cnt(3, 1'b1, n);
      check(32'(n + 1), 32'(4 * (1 + div_set)));
    end
    $display("divider test done");
  endtask : t_div

  task automatic t_slow();
    // slow converter, divided clock, back to back entries
    conv_cyc = 12'h12c;
    run_one(3'h3, 1'b1, 1'b0, 8'h05);
    run_one(3'h4, 1'b1, 1'b1, 8'h00);
    $display("slow converter test done");
  endtask : t_slow

  // reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_temp();
    t_switch();
    t_div();
    t_slow();
    conclude();
  end
endmodule : testbench
